// *** shared/ppc_pkg.sv ***
// Package: register map, bit masks and reset values of the port pin control
package ppc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;

    // ==========================================================
    // Register offsets
    localparam logic [12:0] OFS_PORT_A_PIN_VALUE = 13'h000c;
    localparam logic [12:0] OFS_PORT_B_PIN_VALUE = 13'h000d;
    localparam logic [12:0] OFS_PORT_C_PIN_VALUE = 13'h000e;
    localparam logic [12:0] OFS_PORT_C_DIRECTION = 13'h0014;
    localparam logic [12:0] OFS_PORT_A_OUTPUT_LATCH = 13'h0018;
    localparam logic [12:0] OFS_PORT_B_OUTPUT_LATCH = 13'h0019;
    localparam logic [12:0] OFS_PORT_C_OUTPUT_LATCH = 13'h001a;
    localparam logic [12:0] OFS_PORT_A_ANALOG_SELECT = 13'h1f38;
    localparam logic [12:0] OFS_PORT_A_PULLUP_ENABLE = 13'h1f39;
    localparam logic [12:0] OFS_PORT_B_ANALOG_SELECT = 13'h1f43;
    localparam logic [12:0] OFS_PORT_B_PULLUP_ENABLE = 13'h1f44;
    localparam logic [12:0] OFS_PORT_C_ANALOG_SELECT = 13'h1f4e;
    localparam logic [12:0] OFS_PORT_C_PULLUP_ENABLE = 13'h1f4f;

    // ==========================================================
    // Implemented bit masks
    localparam logic [7:0] MASK_A_LATCH = 8'h37;
    localparam logic [7:0] MASK_A_PULLUP = 8'h3f;
    localparam logic [7:0] MASK_B = 8'hf0;
    localparam logic [7:0] MASK_C_SMALL = 8'h3f;
    localparam logic [7:0] MASK_C_FULL = 8'hff;
    localparam int PIN3_BIT = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_ANALOG = 8'hff;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;

endpackage : ppc_pkg

// *** hw/ppc_sync.sv ***
// Two-flop synchroniser for a bank of pin inputs
`timescale 1ns/1ps

module ppc_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1;

    // First stage read only by the second
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage1 <= '0;
            o_sync <= '0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end

endmodule : ppc_sync

// *** hw/ppc_top.sv ***
// Port pin control registers for three general-purpose ports
`timescale 1ns/1ps

module ppc_top
    import ppc_pkg::*;
#(
    parameter bit PIN20 = 1'b1
) (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // Configuration
    input wire logic i_external_reset_pin_enable,
    input wire logic [7:0] i_port_a_direction,
    input wire logic [7:0] i_port_b_direction,
    // First port pins
    input wire logic [7:0] i_pa_in,
    output logic [7:0] o_pa_out,
    output logic [7:0] o_pa_oe,
    output logic [7:0] o_pa_pullup,
    output logic [7:0] o_pa_analog,
    // Second port pins
    input wire logic [7:0] i_pb_in,
    output logic [7:0] o_pb_out,
    output logic [7:0] o_pb_oe,
    output logic [7:0] o_pb_pullup,
    output logic [7:0] o_pb_analog,
    // Third port pins
    input wire logic [7:0] i_pc_in,
    output logic [7:0] o_pc_out,
    output logic [7:0] o_pc_oe,
    output logic [7:0] o_pc_pullup,
    output logic [7:0] o_pc_analog
);

    // ==========================================================
    // Reset release
    logic rst_meta;
    logic rst_n;
    logic por_meta;
    logic por_n;

    // Both resets take effect asynchronously and release in step with the clock
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            por_meta <= 1'b0;
            por_n <= 1'b0;
        end else begin
            por_meta <= 1'b1;
            por_n <= por_meta;
        end
    end

    // ==========================================================
    // Mask helpers
    localparam logic [7:0] MASK_C = PIN20 ? MASK_C_FULL : MASK_C_SMALL;

    // Keep implemented bits only
    function automatic logic [7:0] ppc_keep(input logic [7:0] val,
                                            input logic [7:0] mask);
        ppc_keep = val & mask;
    endfunction : ppc_keep

    // Pin value seen by port reads: analog pins read zero
    function automatic logic [7:0] ppc_pin_read(input logic [7:0] pins,
                                                input logic [7:0] analog,
                                                input logic [7:0] mask);
        ppc_pin_read = pins & ~analog & mask;
    endfunction : ppc_pin_read

    // ==========================================================
    // Pin synchronisers
    logic [7:0] pa_sync;
    logic [7:0] pb_sync;
    logic [7:0] pc_sync;

    ppc_sync #(.WIDTH(8)) u_sync_a (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async(i_pa_in),
        .o_sync(pa_sync)
    );

    ppc_sync #(.WIDTH(8)) u_sync_b (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async(i_pb_in),
        .o_sync(pb_sync)
    );

    ppc_sync #(.WIDTH(8)) u_sync_c (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_async(i_pc_in),
        .o_sync(pc_sync)
    );

    // ==========================================================
    // Address decode
    wire hit_a_val = (i_addr == OFS_PORT_A_PIN_VALUE);
    wire hit_b_val = (i_addr == OFS_PORT_B_PIN_VALUE);
    wire hit_c_val = (i_addr == OFS_PORT_C_PIN_VALUE);
    wire hit_c_dir = (i_addr == OFS_PORT_C_DIRECTION);
    wire hit_a_lat = (i_addr == OFS_PORT_A_OUTPUT_LATCH);
    wire hit_b_lat = (i_addr == OFS_PORT_B_OUTPUT_LATCH);
    wire hit_c_lat = (i_addr == OFS_PORT_C_OUTPUT_LATCH);
    wire hit_a_ana = (i_addr == OFS_PORT_A_ANALOG_SELECT);
    wire hit_a_pu = (i_addr == OFS_PORT_A_PULLUP_ENABLE);
    wire hit_b_ana = (i_addr == OFS_PORT_B_ANALOG_SELECT);
    wire hit_b_pu = (i_addr == OFS_PORT_B_PULLUP_ENABLE);
    wire hit_c_ana = (i_addr == OFS_PORT_C_ANALOG_SELECT);
    wire hit_c_pu = (i_addr == OFS_PORT_C_PULLUP_ENABLE);

    // Latch writes come from either the latch or the pin value address
    wire wr_a_lat = i_wr & (hit_a_lat | hit_a_val);
    wire wr_b_lat = i_wr & (hit_b_lat | hit_b_val);
    wire wr_c_lat = i_wr & (hit_c_lat | hit_c_val);

    // ==========================================================
    // Registers
    logic [7:0] port_c_direction;
    logic [7:0] port_a_output_latch;
    logic [7:0] port_b_output_latch;
    logic [7:0] port_c_output_latch;
    logic [7:0] port_a_analog_select;
    logic [7:0] port_a_pullup_enable;
    logic [7:0] port_b_analog_select;
    logic [7:0] port_b_pullup_enable;
    logic [7:0] port_c_analog_select;
    logic [7:0] port_c_pullup_enable;

    // Control registers return to defaults on the i_rst_n reset; power-on reset alone leaves them
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_direction <= RST_DIRECTION & MASK_C;
            port_a_analog_select <= RST_ANALOG & MASK_A_LATCH;
            port_b_analog_select <= RST_ANALOG & MASK_B;
            port_c_analog_select <= RST_ANALOG & MASK_C;
            port_a_pullup_enable <= RST_PULLUP;
            port_b_pullup_enable <= RST_PULLUP;
            port_c_pullup_enable <= RST_PULLUP;
        end else if (i_wr) begin
            if (hit_c_dir) begin
                port_c_direction <= ppc_keep(i_wdata, MASK_C);
            end
            if (hit_a_ana) begin
                port_a_analog_select <= ppc_keep(i_wdata, MASK_A_LATCH);
            end
            if (hit_b_ana) begin
                port_b_analog_select <= ppc_keep(i_wdata, MASK_B);
            end
            if (hit_c_ana) begin
                port_c_analog_select <= ppc_keep(i_wdata, MASK_C);
            end
            if (hit_a_pu) begin
                port_a_pullup_enable <= ppc_keep(i_wdata, MASK_A_PULLUP);
            end
            if (hit_b_pu) begin
                port_b_pullup_enable <= ppc_keep(i_wdata, MASK_B);
            end
            if (hit_c_pu) begin
                port_c_pullup_enable <= ppc_keep(i_wdata, MASK_C);
            end
        end
    end

    // Latches clear only on power-on; other resets leave them alone
    always_ff @(posedge i_core_clk or negedge por_n) begin
        if (!por_n) begin
            port_a_output_latch <= RST_LATCH;
            port_b_output_latch <= RST_LATCH;
            port_c_output_latch <= RST_LATCH;
        end else begin
            if (wr_a_lat) begin
                port_a_output_latch <= ppc_keep(i_wdata, MASK_A_LATCH);
            end
            if (wr_b_lat) begin
                port_b_output_latch <= ppc_keep(i_wdata, MASK_B);
            end
            if (wr_c_lat) begin
                port_c_output_latch <= ppc_keep(i_wdata, MASK_C);
            end
        end
    end

    // ==========================================================
    // Pin control
    wire [7:0] dir_a = i_port_a_direction | ~MASK_A_LATCH;
    wire [7:0] dir_b = i_port_b_direction | ~MASK_B;
    wire [7:0] dir_c = port_c_direction | ~MASK_C;

    // Pull-up on pin3 forced while the external reset pin is in use
    wire [7:0] pa_pu_eff = port_a_pullup_enable |
        ({7'h00, i_external_reset_pin_enable} << PIN3_BIT);

    // Digital pins drive their latch while the direction bit is zero
    assign o_pa_out = port_a_output_latch;
    assign o_pb_out = port_b_output_latch;
    assign o_pc_out = port_c_output_latch;
    assign o_pa_oe = ~dir_a;
    assign o_pb_oe = ~dir_b;
    assign o_pc_oe = ~dir_c;

    // An output pin never keeps its pull-up
    assign o_pa_pullup = pa_pu_eff & dir_a & MASK_A_PULLUP;
    assign o_pb_pullup = port_b_pullup_enable & dir_b;
    assign o_pc_pullup = port_c_pullup_enable & dir_c;

    // Analog routing; software must also set the pin as input
    assign o_pa_analog = port_a_analog_select;
    assign o_pb_analog = port_b_analog_select;
    assign o_pc_analog = port_c_analog_select;

    // ==========================================================
    // Read path
    wire [7:0] pa_read = ppc_pin_read(pa_sync, port_a_analog_select,
        MASK_A_PULLUP) | ({7'h00, i_external_reset_pin_enable} << PIN3_BIT);
    logic [7:0] next_rdata;

    // Pin value reads show pins, latch reads show storage
    always_comb begin
        next_rdata = 8'h00;
        unique case (1'b1)
            hit_a_val: next_rdata = pa_read;
            hit_b_val: next_rdata = ppc_pin_read(pb_sync,
                port_b_analog_select, MASK_B);
            hit_c_val: next_rdata = ppc_pin_read(pc_sync,
                port_c_analog_select, MASK_C);
            hit_c_dir: next_rdata = port_c_direction;
            hit_a_lat: next_rdata = port_a_output_latch;
            hit_b_lat: next_rdata = port_b_output_latch;
            hit_c_lat: next_rdata = port_c_output_latch;
            hit_a_ana: next_rdata = port_a_analog_select;
            hit_a_pu: next_rdata = pa_pu_eff;
            hit_b_ana: next_rdata = port_b_analog_select;
            hit_b_pu: next_rdata = port_b_pullup_enable;
            hit_c_ana: next_rdata = port_c_analog_select;
            hit_c_pu: next_rdata = port_c_pullup_enable;
            default: next_rdata = 8'h00; // Unmapped reads give zero
        endcase
    end

    // Read data stands for one cycle after the strobe only
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? next_rdata : 8'h00;
        end
    end

endmodule : ppc_top

// *** sim/ppc_props.sv ***
// Checker of the port pin control behaviour at the top module ports
`timescale 1ns/1ps

module ppc_props
    import ppc_pkg::*;
#(
    parameter bit PIN20 = 1'b1
) (
    // Clock and resets
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_por_n,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    // Pins and configuration
    input wire logic i_external_reset_pin_enable,
    input wire logic [7:0] i_port_a_direction,
    input wire logic [7:0] o_pa_out,
    input wire logic [7:0] o_pa_pullup,
    input wire logic [7:0] o_pb_out,
    input wire logic [7:0] o_pb_oe,
    input wire logic [7:0] o_pc_out,
    input wire logic [7:0] o_pc_oe,
    input wire logic [7:0] o_pc_pullup,
    input wire logic [7:0] o_pc_analog
);
    // ==========================================================
    // Assertions
    // Small parts lose third-port bits 6 and 7
    localparam logic [7:0] CM = PIN20 ? 8'hff : 8'h3f;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    dir_drive_a: assert property (
        i_wr && i_addr == 13'h0014 |=> o_pc_oe == (~$past(i_wdata) & CM))
        else $error("direction write not seen on enables");
    latch_write_a: assert property (
        i_wr && (i_addr == 13'h001a || i_addr == 13'h000e)
        |=> o_pc_out == ($past(i_wdata) & CM))
        else $error("latch write not seen on outputs");
    latch_read_a: assert property (
        i_rd && i_addr == 13'h001a |=> o_rdata == $past(o_pc_out))
        else $error("latch read differs from latch");
    analog_write_a: assert property (
        i_wr && i_addr == 13'h1f4e |=> o_pc_analog == ($past(i_wdata) & CM))
        else $error("analog write not seen");
    pullup_output_a: assert property (
        (o_pc_pullup & o_pc_oe) == 8'h00)
        else $error("pull-up on driven pin");
    pullup_first_a: assert property (
        (o_pa_pullup & ~i_port_a_direction & 8'hf7) == 8'h00)
        else $error("pull-up on first port output");
    reset_pullup_a: assert property (
        i_external_reset_pin_enable [*2] |-> o_pa_pullup[3])
        else $error("pin3 pull-up not forced");
    unimpl_bits_a: assert property (
        ((o_pa_out & 8'hc8) | ((o_pb_out | o_pb_oe) & 8'h0f)) == 8'h00)
        else $error("unimplemented bit active");
    small_part_a: assert property (
        PIN20 || ((o_pc_out | o_pc_oe | o_pc_pullup) & 8'hc0) == 8'h00)
        else $error("bits 6 and 7 active on small part");
    latch_hold_a: assert property (
        disable iff (!i_por_n) !i_wr |=> $stable(o_pc_out))
        else $error("latch changed without write");

    // Main scenarios reached
    cover property (i_wr && i_addr == 13'h000e);
    cover property (i_rd ##1 o_rdata != 8'h00);
    cover property (i_external_reset_pin_enable && o_pa_pullup[3]);
endmodule : ppc_props

bind ppc_top ppc_props #(.PIN20(PIN20)) u_props (
    .i_core_clk, .i_rst_n, .i_por_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_external_reset_pin_enable, .i_port_a_direction,
    .o_pa_out, .o_pa_pullup, .o_pb_out, .o_pb_oe, .o_pc_out, .o_pc_oe,
    .o_pc_pullup, .o_pc_analog
);

// *** sim/ppc_pin_model.sv ***
// Behavioural model of the package pins of one port
`timescale 1ns/1ps

module ppc_pin_model (
    // Clock
    input wire logic i_core_clk,
    // Device side
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_pullup,
    // Outside world
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_ext_en,
    output logic [7:0] o_pin
);
    logic [7:0] float_lvl = 8'h55;
    // Undriven pins wander, so no stale level can be relied on
    always @(posedge i_core_clk) float_lvl <= ~float_lvl;
    // Device drive wins, then outside drive, then pull-up
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
        | (~i_oe & ~i_ext_en & (i_pullup | float_lvl));
endmodule : ppc_pin_model

// *** sim/ppc_top_bench.sv ***
// Self-checking bench of the port pin control registers
`timescale 1ns/1ps

module ppc_top_bench;
    import ppc_pkg::*;
    logic i_core_clk = 0, i_rst_n = 0, i_por_n = 0, i_wr = 0, i_rd = 0;
    logic i_external_reset_pin_enable = 0;
    logic [12:0] i_addr = '0;
    logic [7:0] i_wdata = '0, i_port_a_direction = 8'hff;
    logic [7:0] i_port_b_direction = 8'hff, ext = '0, ext_en = 8'hff;
    logic [7:0] o_rdata, i_pa_in, i_pb_in, i_pc_in, v, d;
    logic [7:0] o_pa_out, o_pa_oe, o_pa_pullup, o_pa_analog;
    logic [7:0] o_pb_out, o_pb_oe, o_pb_pullup, o_pb_analog;
    logic [7:0] o_pc_out, o_pc_oe, o_pc_pullup, o_pc_analog;
    int bad_count = 0, checks_done = 0, i, n;
    logic [12:0] ra [10] = '{13'h0014, 13'h0018, 13'h0019, 13'h001a,
        13'h1f38, 13'h1f39, 13'h1f43, 13'h1f44, 13'h1f4e, 13'h1f4f};
    logic [7:0] rm [10] = '{8'hff, 8'h37, 8'hf0, 8'hff, 8'h37, 8'h3f,
        8'hf0, 8'hf0, 8'hff, 8'hff};
    logic [7:0] rr [10] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h37, 8'h00,
        8'hf0, 8'h00, 8'hff, 8'h00};

    ppc_top dut (.i_core_clk, .i_rst_n, .i_por_n, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_external_reset_pin_enable, .i_port_a_direction,
        .i_port_b_direction, .i_pa_in, .o_pa_out, .o_pa_oe, .o_pa_pullup,
        .o_pa_analog, .i_pb_in, .o_pb_out, .o_pb_oe, .o_pb_pullup,
        .o_pb_analog, .i_pc_in, .o_pc_out, .o_pc_oe, .o_pc_pullup,
        .o_pc_analog);
    ppc_pin_model pins_a (.i_core_clk, .i_out(o_pa_out), .i_oe(o_pa_oe),
        .i_pullup(o_pa_pullup), .i_ext(ext), .i_ext_en(ext_en),
        .o_pin(i_pa_in));
    ppc_pin_model pins_b (.i_core_clk, .i_out(o_pb_out), .i_oe(o_pb_oe),
        .i_pullup(o_pb_pullup), .i_ext(ext), .i_ext_en(ext_en),
        .o_pin(i_pb_in));
    ppc_pin_model pins_c (.i_core_clk, .i_out(o_pc_out), .i_oe(o_pc_oe),
        .i_pullup(o_pc_pullup), .i_ext(ext), .i_ext_en(ext_en),
        .o_pin(i_pc_in));

    // Small part beside the full one, so bits 6 and 7 are seen missing
    logic [7:0] sm_pc_out, sm_pc_oe;
    ppc_top #(.PIN20(1'b0)) dut_small (.i_core_clk, .i_rst_n, .i_por_n,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata(),
        .i_external_reset_pin_enable, .i_port_a_direction,
        .i_port_b_direction, .i_pa_in, .o_pa_out(), .o_pa_oe(),
        .o_pa_pullup(), .o_pa_analog(), .i_pb_in, .o_pb_out(), .o_pb_oe(),
        .o_pb_pullup(), .o_pb_analog(), .i_pc_in, .o_pc_out(sm_pc_out),
        .o_pc_oe(sm_pc_oe), .o_pc_pullup(), .o_pc_analog());

    // ==========================================================
    // Clock, bus tasks and checks
    initial forever #4 i_core_clk = ~i_core_clk;

    task automatic wr(input logic [12:0] a, input logic [7:0] dv);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= dv;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [12:0] a, output logic [7:0] rv);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(posedge i_core_clk);
        rv = o_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("Error %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    // Pin read with all pull-ups on; analog pins read zero
    function automatic logic [7:0] pin_exp(input logic [7:0] lat, dir,
        anl, ex, en);
        return ((~dir & lat) | (dir & en & ex) | (dir & ~en)) & ~anl;
    endfunction : pin_exp

    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_core_clk);
        bad_count++;
        end_sim;
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(81631));
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        i_por_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        for (i = 0; i < 10; i++) begin
            rd(ra[i], v);
            chk(v, rr[i]);
        end
        for (n = 0; n < 4; n++) begin
            for (i = 0; i < 10; i++) begin
                d = 8'($urandom);
                i_port_a_direction <= 8'($urandom);
                i_port_b_direction <= 8'($urandom);
                wr(ra[i], d);
                rd(ra[i], v);
                chk(v, d & rm[i]);
            end
        end
        d = 8'($urandom);
        ext <= 8'($urandom);
        wr(13'h000e, d);
        wr(13'h0014, 8'hf0);
        wr(13'h1f4e, 8'h80);
        wr(13'h1f4f, 8'hff);
        rd(13'h001a, v);
        chk(v, d);
        chk(o_pc_out, d);
        chk(o_pc_oe, 8'h0f);
        chk(o_pc_pullup, 8'hf0);
        chk(o_pc_analog, 8'h80);
        chk(sm_pc_out, d & 8'h3f);
        chk(sm_pc_oe, 8'h0f);
        repeat (3) @(posedge i_core_clk);
        rd(13'h000e, v);
        chk(v, pin_exp(d, 8'hf0, 8'h80, ext, 8'hff));
        ext_en <= 8'h00;
        repeat (3) @(posedge i_core_clk);
        rd(13'h000e, v);
        chk(v, pin_exp(d, 8'hf0, 8'h80, ext, 8'h00));
        i_external_reset_pin_enable <= 1'b1;
        wr(13'h1f39, 8'h00);
        rd(13'h1f39, v);
        chk(v, 8'h08);
        chk(o_pa_pullup & 8'h08, 8'h08);
        i_external_reset_pin_enable <= 1'b0;
        wr(13'h0015, 8'hff);
        rd(13'h0015, v);
        chk(v, 8'h00);
        // First and second ports: drive, pull-up, analog and pin reads
        i_port_a_direction <= 8'hf0;
        i_port_b_direction <= 8'h3f;
        wr(13'h000c, d);
        wr(13'h000d, d);
        wr(13'h1f38, 8'h20);
        wr(13'h1f43, 8'h00);
        wr(13'h1f39, 8'h3f);
        wr(13'h1f44, 8'hff);
        repeat (3) @(posedge i_core_clk);
        chk(o_pa_out, d & 8'h37);
        chk(o_pa_oe, 8'h07);
        chk(o_pa_pullup, 8'h38);
        chk(o_pa_analog, 8'h20);
        chk(o_pb_out, d & 8'hf0);
        chk(o_pb_oe, 8'hc0);
        chk(o_pb_pullup, 8'h30);
        chk(o_pb_analog, 8'h00);
        rd(13'h000c, v);
        chk(v, pin_exp(d & 8'h37, 8'hf8, 8'he0, ext, 8'h00));
        rd(13'h000d, v);
        chk(v, pin_exp(d & 8'hf0, 8'h3f, 8'h0f, ext, 8'h00));
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        chk(o_pc_out, d);
        chk(o_pa_out, d & 8'h37);
        rd(13'h0014, v);
        chk(v, 8'hff);
        end_sim;
    end
endmodule : ppc_top_bench
